// ### logic/cpu_register_model.sv
// programming-model registers, stack sequencing and interrupt entry
//
// Overview of operation
// - eight-bit accumulator holds operands and results of operations.
// - indexed address is index pointer plus unsigned eight-bit offset; in data space only the low byte of the sum is used.
// - indexed writes into code space are suppressed; reads only.
// - index pointer high nibble and low byte mapped at 0xbe, 0xbf.
// - top index bit is write-only, selects data or program space.
// - only the low eleven index bits count; top bit stays put.
// - eleven-bit program counter, reset points at 0x800.
// - four-bit stack pointer in page 0x30-0x3f, resets to 0xf.
// - stack grows downward, two per pushed or pulled address.
// - call pushes return address low byte first; return reloads it.
// - eight-bit status: carry, half, zero, negative, mask, write flag.
// - carry from arithmetic and from set, clear, load, invert ops.
// - rotates go through carry in both directions.
// - half carry records carry out of the low nibble.
// - zero flag set when the result is zero, else cleared.
// - negative flag copies result bit seven.
// - maskable requests wait while mask clear; taken while set.
// - reset clears the mask; only software sets it again.
// - interrupt entry stacks pc, fetches vector, then clears mask.
// - interrupt return restores pc from stack and sets the mask.
// - index, stack pointer and status reachable as memory locations.
// - interrupt entry takes five cycles to the vector.
// - software trap ignores mask and raises no irq_ack_q; otherwise same as interrupt entry.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_model (
  input  wire  logic              sys_clk,
  input  wire  logic              nrst,
  input  wire  cpu_regs_pkg::op_t op,
  input  wire  logic              op_valid,
  input  wire  logic [7:0]        operand,
  input  wire  logic [11:0]       target,
  input  wire  logic              instr_done,
  input  wire  logic              irq_pending,
  input  wire  logic [11:0]       vector_addr,
  input  wire  logic              ee_busy,
  input  wire  logic [7:0]        mem_rdata,
  input  wire  logic [7:0]        mm_addr,
  input  wire  logic              mm_wr,
  input  wire  logic              mm_rd,
  input  wire  logic [7:0]        mm_wdata,
  output logic [7:0]              accumulator_q,
  output logic [11:0]             index_pointer_q,
  output logic [11:0]             instruction_pointer_q,
  output logic [3:0]              stack_ptr_reg_q,
  output logic [7:0]              flag_register_q,
  output logic                    busy_q,
  output logic                    irq_ack_q,
  output logic [11:0]             mem_addr_q,
  output logic                    mem_rd_q,
  output logic                    mem_wr_q,
  output logic [7:0]              mem_wdata_q,
  output logic [7:0]              mm_rdata_q,
  output logic                    mm_rvalid_q
);
  import cpu_regs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle, st_push_lo, st_push_hi, st_vec_lo, st_vec_hi, st_vec_load,
    st_pull_hi, st_pull_lo, st_idx_rd
  } seq_state_t;

  seq_state_t  state_q, state_d;
  logic [7:0]  a_d;
  logic [11:0] x_d;
  logic [10:0] pc_q, pc_d;
  logic [3:0]  sp_d;
  logic [7:0]  sr_d;
  logic [7:0]  tmp_q, tmp_d;
  logic [11:0] vec_q, vec_d;
  logic        call_q, call_d;
  logic        interrupt_exit_op_q, interrupt_exit_op_d;
  logic        irq_ack_d;
  logic [11:0] mem_addr_d;
  logic        mem_rd_d;
  logic        mem_wr_d;
  logic [7:0]  mem_wdata_d;
  logic [7:0]  mm_rdata_d;
  logic        mm_rvalid_d;
  logic        take_irq;
  logic        take_trap;
  logic        alu_apply;

  cpu_regs_pkg::op_t alu_op;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_h;
  logic        alu_wr_a;
  logic        alu_wr_c;
  logic        alu_wr_h;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] stack_addr(input logic [3:0] p);
    stack_addr = {4'h0, STACK_PAGE, p};
  endfunction

  // only the low eleven bits take the offset; bit 11 picks the space
  function automatic logic [11:0] idx_addr(input logic [11:0] x,
                                           input logic [7:0]  off);
    logic [10:0] sum;
    sum = x[10:0] + {3'h0, off};
    idx_addr = x[11] ? {1'b1, sum} : {4'h0, sum[7:0]};
  endfunction

  function automatic logic [7:0] mm_read(input logic [7:0] adr,
                                         input logic [11:0] x,
                                         input logic [3:0]  sp,
                                         input logic [7:0]  sr);
    case (adr)
      XHI_OFS: mm_read = {5'h00, x[10:8]};
      XLO_OFS: mm_read = x[7:0];
      SP_OFS:  mm_read = {4'h0, sp};
      SR_OFS:  mm_read = sr;
      default: mm_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // accumulator datapath; indexed reads reuse the load path for flags
  // ----------------------------------------------------------------
  assign alu_op = (state_q == st_idx_rd) ? ld_a_op : op;
  assign alu_b  = (state_q == st_idx_rd) ? mem_rdata : operand;

  flag_alu u_alu (
    .op    (alu_op),
    .a     (accumulator_q),
    .b     (alu_b),
    .c_in  (flag_register_q[SR_C]),
    .res   (alu_res),
    .c_out (alu_c),
    .h_out (alu_h),
    .wr_a  (alu_wr_a),
    .wr_c  (alu_wr_c),
    .wr_h  (alu_wr_h)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  assign take_trap = op_valid && (op == software_trap_op);
  // maskable requests only at an instruction boundary with the mask set
  assign take_irq  = instr_done && irq_pending
                     && flag_register_q[SR_G];

  always_comb begin
    state_d     = state_q;
    a_d         = accumulator_q;
    x_d         = index_pointer_q;
    pc_d        = pc_q;
    sp_d        = stack_ptr_reg_q;
    sr_d        = flag_register_q;
    tmp_d       = tmp_q;
    vec_d       = vec_q;
    call_d      = call_q;
    interrupt_exit_op_d      = interrupt_exit_op_q;
    irq_ack_d   = 1'b0;
    mem_addr_d  = mem_addr_q;
    mem_rd_d    = 1'b0;
    mem_wr_d    = 1'b0;
    mem_wdata_d = mem_wdata_q;
    mm_rdata_d  = mm_rdata_q;
    mm_rvalid_d = 1'b0;
    alu_apply   = 1'b0;
    case (state_q)
      st_idle: begin
        if (take_irq || take_trap) begin
          irq_ack_d   = take_irq;
          vec_d       = vector_addr;
          call_d      = 1'b0;
          state_d     = st_push_lo;
          mem_wr_d    = 1'b1;
          mem_addr_d  = stack_addr(stack_ptr_reg_q);
          mem_wdata_d = pc_q[7:0];
        end else if (op_valid) begin
          case (op)
            call_subroutine_op: begin
              vec_d       = target;
              call_d      = 1'b1;
              state_d     = st_push_lo;
              mem_wr_d    = 1'b1;
              mem_addr_d  = stack_addr(stack_ptr_reg_q);
              mem_wdata_d = pc_q[7:0];
            end
            subroutine_exit_op, interrupt_exit_op: begin
              interrupt_exit_op_d     = (op == interrupt_exit_op);
              state_d    = st_pull_hi;
              mem_rd_d   = 1'b1;
              mem_addr_d = stack_addr(stack_ptr_reg_q + 4'h1);
            end
            idx_read_op: begin
              state_d    = st_idx_rd;
              mem_rd_d   = 1'b1;
              mem_addr_d = idx_addr(index_pointer_q, operand);
            end
            idx_write_op: begin
              mem_wr_d    = ~index_pointer_q[11];
              mem_addr_d  = idx_addr(index_pointer_q, operand);
              mem_wdata_d = accumulator_q;
            end
            ld_x_op:  x_d = target;
            inc_x_op: x_d[10:0] = index_pointer_q[10:0] + 11'h001;
            dec_x_op: x_d[10:0] = index_pointer_q[10:0] - 11'h001;
            set_g_op: sr_d[SR_G] = 1'b1;
            clr_g_op: sr_d[SR_G] = 1'b0;
            jmp_op:   pc_d = target[10:0];
            step_op:  pc_d = pc_q + 11'h001;
            default:  alu_apply = 1'b1;
          endcase
        end
      end
      st_push_lo: begin
        state_d     = st_push_hi;
        mem_wr_d    = 1'b1;
        mem_addr_d  = stack_addr(stack_ptr_reg_q - 4'h1);
        mem_wdata_d = {5'h00, pc_q[10:8]};
      end
      st_push_hi: begin
        sp_d = stack_ptr_reg_q - PUSH_STEP;
        if (call_q) begin
          pc_d    = vec_q[10:0];
          state_d = st_idle;
        end else begin
          state_d    = st_vec_lo;
          mem_rd_d   = 1'b1;
          mem_addr_d = vec_q;
        end
      end
      st_vec_lo: begin
        tmp_d      = mem_rdata;
        state_d    = st_vec_hi;
        mem_rd_d   = 1'b1;
        mem_addr_d = vec_q + 12'h001;
      end
      st_vec_hi: begin
        pc_d    = {mem_rdata[2:0], tmp_q};
        state_d = st_vec_load;
      end
      // mask drops only once pc is stacked and the vector is in
      st_vec_load: begin
        sr_d[SR_G] = 1'b0;
        state_d    = st_idle;
      end
      st_pull_hi: begin
        tmp_d      = mem_rdata;
        state_d    = st_pull_lo;
        mem_rd_d   = 1'b1;
        mem_addr_d = stack_addr(stack_ptr_reg_q + PUSH_STEP);
      end
      st_pull_lo: begin
        pc_d    = {tmp_q[2:0], mem_rdata};
        sp_d    = stack_ptr_reg_q + PUSH_STEP;
        state_d = st_idle;
        if (interrupt_exit_op_q) begin
          sr_d[SR_G] = 1'b1;
        end
      end
      st_idx_rd: begin
        alu_apply = 1'b1;
        state_d   = st_idle;
      end
      default: state_d = st_idle;
    endcase
    if (alu_apply) begin
      if (alu_wr_a) begin
        a_d        = alu_res;
        sr_d[SR_Z] = (alu_res == 8'h00);
        sr_d[SR_N] = alu_res[7];
      end
      if (alu_wr_c) begin
        sr_d[SR_C] = alu_c;
      end
      if (alu_wr_h) begin
        sr_d[SR_H] = alu_h;
      end
    end
    // memory-mapped writes land last, so software wins a same-cycle clash
    if (mm_wr) begin
      case (mm_addr)
        XHI_OFS: x_d[11:8] = mm_wdata[3:0];
        XLO_OFS: x_d[7:0]  = mm_wdata;
        SP_OFS:  sp_d      = mm_wdata[3:0];
        SR_OFS:  sr_d      = mm_wdata & SR_WMASK;
        default: ;
      endcase
    end
    // write flag mirrors the eeprom controller and is reloaded from ee_busy every cycle
    sr_d[SR_R] = ee_busy;
    sr_d[7:6]  = 2'b00;
    if (mm_rd) begin
      mm_rvalid_d = 1'b1;
      mm_rdata_d  = mm_read(mm_addr, index_pointer_q, stack_ptr_reg_q,
                            flag_register_q);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q               <= st_idle;
      accumulator_q         <= A_RESET;
      index_pointer_q       <= X_RESET;
      pc_q                  <= PC_RESET[10:0];
      instruction_pointer_q <= PC_RESET;
      stack_ptr_reg_q       <= SP_RESET;
      flag_register_q       <= SR_RESET;
      tmp_q                 <= 8'h00;
      vec_q                 <= 12'h000;
      call_q                <= 1'b0;
      interrupt_exit_op_q                <= 1'b0;
      busy_q                <= 1'b0;
      irq_ack_q             <= 1'b0;
      mem_addr_q            <= 12'h000;
      mem_rd_q              <= 1'b0;
      mem_wr_q              <= 1'b0;
      mem_wdata_q           <= 8'h00;
      mm_rdata_q            <= 8'h00;
      mm_rvalid_q           <= 1'b0;
    end else begin
      state_q               <= state_d;
      accumulator_q         <= a_d;
      index_pointer_q       <= x_d;
      pc_q                  <= pc_d;
      instruction_pointer_q <= {1'b1, pc_d};  // program space view
      stack_ptr_reg_q       <= sp_d;
      flag_register_q       <= sr_d;
      tmp_q                 <= tmp_d;
      vec_q                 <= vec_d;
      call_q                <= call_d;
      interrupt_exit_op_q                <= interrupt_exit_op_d;
      busy_q                <= (state_d != st_idle);
      irq_ack_q             <= irq_ack_d;
      mem_addr_q            <= mem_addr_d;
      mem_rd_q              <= mem_rd_d;
      mem_wr_q              <= mem_wr_d;
      mem_wdata_q           <= mem_wdata_d;
      mm_rdata_q            <= mm_rdata_d;
      mm_rvalid_q           <= mm_rvalid_d;
    end
  end

endmodule
`default_nettype wire

// ### logic/cpu_regs_pkg.sv
// constants, opcodes and register map of the core register model
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int X_W    = 12;
  localparam int PC_W   = 11;
  localparam int SP_W   = 4;

  // ----------------------------------------------------------------
  // memory-mapped offsets (data space)
  // ----------------------------------------------------------------
  localparam logic [7:0] XHI_OFS = 8'hbe;
  localparam logic [7:0] XLO_OFS = 8'hbf;
  localparam logic [7:0] SP_OFS  = 8'hbd;
  localparam logic [7:0] SR_OFS  = 8'hbc;

  // ----------------------------------------------------------------
  // reset values and stack layout
  // ----------------------------------------------------------------
  localparam logic [11:0] PC_RESET   = 12'h800;
  localparam logic [3:0]  SP_RESET   = 4'hf;
  localparam logic [3:0]  STACK_PAGE = 4'h3;
  localparam logic [3:0]  PUSH_STEP  = 4'h2;
  localparam logic [7:0]  A_RESET    = 8'h00;
  localparam logic [11:0] X_RESET    = 12'h000;
  localparam logic [7:0]  SR_RESET   = 8'h00;
  localparam int          INT_ENTRY_CYCLES = 5;

  // ----------------------------------------------------------------
  // status byte layout; bits 6 and 7 read zero
  // ----------------------------------------------------------------
  localparam int SR_C = 0;
  localparam int SR_H = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_G = 4;
  localparam int SR_R = 5;
  localparam logic [7:0] SR_WMASK = 8'h1f;

  // ----------------------------------------------------------------
  // operations issued by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    nop_op, ld_a_op, add_op, adc_op, subc_op, and_op, or_op, xor_op,
    inc_a_op, dec_a_op, clr_a_op, rlc_op, rrc_op, set_carry_op,
    clr_carry_op, load_carry_op, invert_carry_op, ld_x_op, inc_x_op,
    dec_x_op, set_g_op, clr_g_op, jmp_op, step_op, idx_read_op,
    idx_write_op, call_subroutine_op, subroutine_exit_op,
    interrupt_exit_op, software_trap_op
  } op_t;

endpackage

// ### logic/flag_alu.sv
// accumulator arithmetic, logic, rotate and carry manipulation
`timescale 1ns/1ps
`default_nettype none
module flag_alu (
  input  wire  cpu_regs_pkg::op_t op,
  input  wire  logic [7:0]        a,
  input  wire  logic [7:0]        b,
  input  wire  logic              c_in,
  output logic [7:0]              res,
  output logic                    c_out,
  output logic                    h_out,
  output logic                    wr_a,
  output logic                    wr_c,
  output logic                    wr_h
);
  import cpu_regs_pkg::*;

  logic [7:0] bx;
  logic       cin;
  logic       arith;
  logic [8:0] sum9;
  logic [4:0] lo5;

  always_comb begin
    bx    = b;
    cin   = 1'b0;
    arith = 1'b0;
    res   = a;
    c_out = c_in;
    h_out = 1'b0;
    wr_a  = 1'b0;
    wr_c  = 1'b0;
    wr_h  = 1'b0;
    case (op)
      add_op: arith = 1'b1;
      adc_op: begin
        arith = 1'b1;
        cin   = c_in;
      end
      // subtract as add of the complement; carry out low means borrow
      subc_op: begin
        arith = 1'b1;
        bx    = ~b;
        cin   = c_in;
      end
      ld_a_op:  begin res = b;       wr_a = 1'b1; end
      and_op:   begin res = a & b;   wr_a = 1'b1; end
      or_op:    begin res = a | b;   wr_a = 1'b1; end
      xor_op:   begin res = a ^ b;   wr_a = 1'b1; end
      inc_a_op: begin res = a + 8'h01; wr_a = 1'b1; end
      dec_a_op: begin res = a - 8'h01; wr_a = 1'b1; end
      clr_a_op: begin res = 8'h00;   wr_a = 1'b1; end
      rlc_op: begin
        res   = {a[6:0], c_in};
        c_out = a[7];
        wr_a  = 1'b1;
        wr_c  = 1'b1;
      end
      rrc_op: begin
        res   = {c_in, a[7:1]};
        c_out = a[0];
        wr_a  = 1'b1;
        wr_c  = 1'b1;
      end
      set_carry_op:    begin c_out = 1'b1;  wr_c = 1'b1; end
      clr_carry_op:    begin c_out = 1'b0;  wr_c = 1'b1; end
      load_carry_op:   begin c_out = b[0];  wr_c = 1'b1; end
      invert_carry_op: begin c_out = ~c_in; wr_c = 1'b1; end
      default: ;
    endcase
    sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    lo5  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    if (arith) begin
      res   = sum9[7:0];
      c_out = sum9[8];
      h_out = lo5[4];
      wr_a  = 1'b1;
      wr_c  = 1'b1;
      wr_h  = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### sim/cpu_register_model_asserts.sv
// port-level assertions for the register model
`timescale 1ns/1ps
`default_nettype none
module cpu_register_model_asserts (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire cpu_regs_pkg::op_t op,
  input wire logic        op_valid,
  input wire logic [7:0]  operand,
  input wire logic [11:0] target,
  input wire logic        instr_done,
  input wire logic        irq_pending,
  input wire logic [11:0] vector_addr,
  input wire logic        ee_busy,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  mm_addr,
  input wire logic        mm_wr,
  input wire logic        mm_rd,
  input wire logic [7:0]  mm_wdata,
  input wire logic [7:0]  accumulator_q,
  input wire logic [11:0] index_pointer_q,
  input wire logic [11:0] instruction_pointer_q,
  input wire logic [3:0]  stack_ptr_reg_q,
  input wire logic [7:0]  flag_register_q,
  input wire logic        busy_q,
  input wire logic        irq_ack_q,
  input wire logic [11:0] mem_addr_q,
  input wire logic        mem_rd_q,
  input wire logic        mem_wr_q,
  input wire logic [7:0]  mem_wdata_q,
  input wire logic [7:0]  mm_rdata_q,
  input wire logic        mm_rvalid_q
);
  import cpu_regs_pkg::*;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // a maskable request outranks any offered op
  wire logic irq_w = instr_done && irq_pending && flag_register_q[SR_G];
  wire logic take = op_valid && !busy_q && !irq_w;

  property p_reset_vals;
    $rose(nrst) |-> stack_ptr_reg_q == 4'hf &&
      instruction_pointer_q == 12'h800 && !flag_register_q[SR_G];
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  property p_call_push;
    take && op == call_subroutine_op |=> mem_wr_q &&
      mem_addr_q == {8'h03, $past(stack_ptr_reg_q)} &&
      mem_wdata_q == $past(instruction_pointer_q[7:0]) ##1 mem_wr_q &&
      mem_addr_q == {8'h03, $past(stack_ptr_reg_q, 2) - 4'h1};
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call push order wrong");
  property p_call_done;
    take && op == call_subroutine_op |-> ##3 !busy_q &&
      stack_ptr_reg_q == $past(stack_ptr_reg_q, 3) - 4'h2 &&
      instruction_pointer_q[10:0] == $past(target[10:0], 3);
  endproperty
  a_call_done: assert property (p_call_done)
    else $error("call result wrong");
  property p_ret;
    take && (op == subroutine_exit_op || op == interrupt_exit_op) |->
      ##3 !busy_q && stack_ptr_reg_q == $past(stack_ptr_reg_q, 3) + 4'h2;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return stack step wrong");
  property p_interrupt_exit_op_g;
    take && op == interrupt_exit_op |-> ##3 flag_register_q[SR_G];
  endproperty
  a_interrupt_exit_op_g: assert property (p_interrupt_exit_op_g)
    else $error("mask not set by interrupt return");
  property p_irq_take;
    instr_done && irq_pending && !busy_q |=>
      irq_ack_q == $past(flag_register_q[SR_G]);
  endproperty
  a_irq_take: assert property (p_irq_take)
    else $error("maskable request handling wrong");
  property p_entry;
    irq_ack_q |-> (busy_q && flag_register_q[SR_G]) [*5] ##1
      (!busy_q && !flag_register_q[SR_G]);
  endproperty
  a_entry: assert property (p_entry)
    else $error("interrupt entry timing wrong");
  property p_trap;
    op_valid && !busy_q && op == software_trap_op |=> busy_q [*5] ##1
      (!busy_q && !flag_register_q[SR_G]);
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap entry wrong");
  property p_no_code_wr;
    mem_wr_q |-> !mem_addr_q[11];
  endproperty
  a_no_code_wr: assert property (p_no_code_wr)
    else $error("write into code space");
  property p_status_fixed;
    1'b1 |=> flag_register_q[7:6] == 2'b00 &&
      flag_register_q[SR_R] == $past(ee_busy);
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("status fixed bits wrong");
  property p_xhi_read;
    mm_rd && mm_addr == 8'hbe |=> mm_rvalid_q &&
      mm_rdata_q == {5'h00, $past(index_pointer_q[10:8])};
  endproperty
  a_xhi_read: assert property (p_xhi_read)
    else $error("index high read wrong");
endmodule
bind cpu_register_model cpu_register_model_asserts u_chk (.*);
`default_nettype wire

// ### sim/mem_model.sv
// memory seen by the register model: data, stack and code space
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] mem_addr_q,
  input  wire logic        mem_rd_q,
  input  wire logic        mem_wr_q,
  input  wire logic [7:0]  mem_wdata_q,
  output logic [7:0]       mem_rdata
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] mem [4096];
  logic [7:0] last_q = 8'h00;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end
  // outside a strobe show the inverted last byte so a late sample fails
  assign mem_rdata = mem_rd_q ? mem[mem_addr_q] : ~last_q;
  always @(posedge sys_clk) begin
    if (mem_rd_q) last_q <= mem[mem_addr_q];
    if (mem_wr_q) mem[mem_addr_q] <= mem_wdata_q;
  end
endmodule
`default_nettype wire

// ### sim/cpu_register_model_tb.sv
// self-checking bench for the register model
`timescale 1ns/1ps
`default_nettype none
module cpu_register_model_tb;
  import cpu_regs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  op_t         op = nop_op;
  logic        op_valid = 1'b0;
  logic [7:0]  operand = 8'h00;
  logic [11:0] target = 12'h000;
  logic        instr_done = 1'b0;
  logic        irq_pending = 1'b0;
  logic [11:0] vector_addr = 12'h0f0;
  logic        ee_busy = 1'b0;
  logic [7:0]  mm_addr = 8'h00;
  logic        mm_wr = 1'b0;
  logic        mm_rd = 1'b0;
  logic [7:0]  mm_wdata = 8'h00;
  logic [7:0]  mem_rdata, accumulator_q, mem_wdata_q, mm_rdata_q;
  logic [7:0]  flag_register_q;
  logic [11:0] index_pointer_q, instruction_pointer_q, mem_addr_q;
  logic [3:0]  stack_ptr_reg_q;
  logic        busy_q, irq_ack_q, mem_rd_q, mem_wr_q, mm_rvalid_q;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  op_t         cop [5] = '{invert_carry_op, clr_carry_op, set_carry_op,
                           invert_carry_op, subc_op};
  logic        cexp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  always #25 sys_clk = ~sys_clk;
  cpu_register_model DUT (.*);
  mem_model mem_i (.*);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait so a stuck busy flag cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge sys_clk);
    while (busy_q !== 1'b0 && n < 20) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 20) failures++;
  endtask

  task automatic do_op(input op_t o, input logic [7:0] d = 8'h00,
                       input logic [11:0] t = 12'h000);
    @(posedge sys_clk);
    op <= o;
    operand <= d;
    target <= t;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    wait_idle();
  endtask

  task automatic mm_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    mm_addr <= a;
    mm_wdata <= d;
    mm_wr <= 1'b1;
    @(posedge sys_clk);
    mm_wr <= 1'b0;
  endtask

  task automatic mm_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    mm_addr <= a;
    mm_rd <= 1'b1;
    @(posedge sys_clk);
    mm_rd <= 1'b0;
    @(negedge sys_clk);
    chk({7'h00, mm_rvalid_q, mm_rdata_q}, {8'h01, e});
  endtask

  task automatic do_rst();
    @(posedge sys_clk);
    nrst <= 1'b0;
    ee_busy <= 1'b0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
  endtask

  // request held three edges; the pointer must show e afterwards
  task automatic irq_try(input logic [11:0] e);
    @(posedge sys_clk);
    instr_done <= 1'b1;
    irq_pending <= 1'b1;
    repeat (3) @(posedge sys_clk);
    instr_done <= 1'b0;
    irq_pending <= 1'b0;
    wait_idle();
    chk(instruction_pointer_q, e);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_rst();
    chk({accumulator_q, flag_register_q}, 16'h0000);
    chk({stack_ptr_reg_q, instruction_pointer_q}, 16'hf800);
    mm_write(8'hbf, 8'h12);
    mm_write(8'hbe, 8'h0f);
    mm_read(8'hbf, 8'h12);
    mm_read(8'hbe, 8'h07);
    chk(index_pointer_q, 16'h0f12);
    mm_write(8'hbd, 8'h09);
    mm_read(8'hbd, 8'h09);
    mm_write(8'hbc, 8'hff);
    mm_read(8'hbc, 8'h1f);
    mm_write(8'h20, 8'h55);
    mm_read(8'h20, 8'h00);
    @(posedge sys_clk);
    ee_busy <= 1'b1;
    mm_read(8'hbc, 8'h3f);
    do_rst();
    chk({stack_ptr_reg_q, 4'h0, flag_register_q}, 16'hf000);
    do_op(ld_a_op, 8'h80);
    chk(flag_register_q[3:2], 16'h0002);
    do_op(add_op, 8'h80);
    chk({accumulator_q, flag_register_q[3:0]}, 16'h0005);
    do_op(ld_a_op, 8'h0f);
    do_op(add_op, 8'h01);
    chk({accumulator_q, flag_register_q[3:0]}, 16'h0102);
    do_op(clr_carry_op);
    do_op(ld_a_op, 8'h81);
    do_op(rlc_op);
    chk({accumulator_q, flag_register_q[0]}, 16'h0005);
    do_op(rrc_op);
    chk({accumulator_q, flag_register_q[0]}, 16'h0102);
    for (int i = 0; i < 5; i++) begin
      do_op(cop[i]);
      chk(flag_register_q[0], {15'h0000, cexp[i]});
    end
    do_op(ld_x_op, 8'h00, 12'h010);
    do_op(idx_read_op, 8'hf5);
    chk(accumulator_q, 16'h005f);
    do_op(ld_x_op, 8'h00, 12'h8ff);
    do_op(idx_read_op, 8'h01);
    chk(accumulator_q, 16'h005a);
    do_op(ld_a_op, 8'h33);
    do_op(idx_write_op, 8'h01);
    do_op(idx_read_op, 8'h01);
    chk(accumulator_q, 16'h005a);
    do_op(ld_x_op, 8'h00, 12'hfff);
    do_op(inc_x_op);
    chk(index_pointer_q, 16'h0800);
    do_op(dec_x_op);
    chk(index_pointer_q, 16'h0fff);
    do_op(call_subroutine_op, 8'h00, 12'h123);
    chk({stack_ptr_reg_q, instruction_pointer_q}, 16'hd923);
    do_op(subroutine_exit_op);
    chk({stack_ptr_reg_q, instruction_pointer_q}, 16'hf800);
    irq_try(12'h800);
    do_op(set_g_op);
    irq_try(12'hbaa);
    chk({stack_ptr_reg_q, 3'h0, flag_register_q[4]}, 16'h00d0);
    do_op(interrupt_exit_op);
    chk({instruction_pointer_q, flag_register_q[4]}, 16'h1001);
    do_op(clr_g_op);
    do_op(software_trap_op);
    chk(instruction_pointer_q, 16'h0baa);
    do_op(subroutine_exit_op);
    chk({stack_ptr_reg_q, instruction_pointer_q}, 16'hf800);
    do_op(jmp_op, 8'h00, 12'h7fe);
    do_op(step_op);
    chk(instruction_pointer_q, 16'h0fff);
    stop_test();
  end
endmodule
`default_nettype wire
